// ### common/regbank_pkg.sv
// Shared constants and types of the per-input threshold and trim registers
package regbank_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned NUM_INPUTS = 8;
    localparam int unsigned NUM_SLOTS = 128;
    localparam int unsigned LIMIT_W = 12;
    localparam int unsigned TRIM_W = 16;
    localparam int unsigned SLOT_CODE_W = 4;
    localparam int unsigned SLOT_IDX_W = 7;
    localparam int unsigned INPUT_IDX_W = 3;
    localparam int unsigned RESULT_W = 16;
    localparam int unsigned RESULT_TOP_LSB = 4;
    localparam int unsigned PADDR_W = 12;
    localparam int unsigned PDATA_W = 32;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [8:0] UPPER_BASE = 9'h040;
    localparam logic [8:0] LOWER_BASE = 9'h060;
    localparam logic [8:0] DEADBAND_BASE = 9'h080;
    localparam logic [8:0] ZERO_TRIM_BASE = 9'h0A0;
    localparam logic [8:0] SCALE_TRIM_BASE = 9'h0C0;
    localparam logic [8:0] FAMILY_SPAN = 9'h00E;
    localparam logic [8:0] SLOT_BASE = 9'h100;
    localparam logic [8:0] SLOT_LAST = 9'h17F;
    localparam logic [8:0] TD_ENABLE_IDX = 9'h180;
    localparam logic [8:0] IRQ_STATUS_IDX = 9'h181;
    localparam logic [8:0] IRQ_MASK_IDX = 9'h182;
    localparam logic [8:0] ALERT_STATE_IDX = 9'h183;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [11:0] UPPER_RST = 12'h7FF;
    localparam logic [11:0] LOWER_RST = 12'h000;
    localparam logic [11:0] DEADBAND_RST = 12'h010;
    localparam logic [15:0] ZERO_TRIM_RST = 16'h0000;
    localparam logic [15:0] SCALE_TRIM_RST = 16'h8000;
    localparam logic [3:0] SLOT_RST = 4'h0;
    localparam logic [7:0] TD_ENABLE_RST = 8'h00;
    localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
    localparam int unsigned HI_FIELD_LSB = 0;
    localparam int unsigned LO_FIELD_LSB = 8;
    localparam int unsigned SLOT_INVALID_BIT = 3;

    // ------------------------------------------------------------------
    // Address decode result
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        REG_NONE = 4'h0,
        REG_UPPER = 4'h1,
        REG_LOWER = 4'h2,
        REG_DEADBAND = 4'h3,
        REG_ZERO_TRIM = 4'h4,
        REG_SCALE_TRIM = 4'h5,
        REG_SLOT = 4'h6,
        REG_TD_ENABLE = 4'h7,
        REG_IRQ_STATUS = 4'h8,
        REG_IRQ_MASK = 4'h9,
        REG_ALERT = 4'hA
    } reg_kind_t;

    typedef struct packed {
        reg_kind_t kind;
        logic [6:0] n;
    } decode_t;

endpackage

// ### rtl/channel_threshold_correction_regs.sv
// Per-input alarm limits, trims and sequencer slots behind an APB slave
//
// Behaviour
// - Eight upper limits at indices 0x40..0x4E step two, 12-bit value.
// - Upper limits reset to 0x07FF; bits 15:12 read zero, not writable.
// - Eight lower limits at 0x60..0x6E step two, reset zero, 12-bit.
// - Eight deadbands at 0x80..0x8E step two, reset 0x0010, 12-bit.
// - Eight 16-bit zero trims at 0xA0..0xAE, reset zero, per input.
// - Eight 16-bit scale trims at 0xC0..0xCE, reset 0x8000, per input.
// - 128 slot registers at 0x100..0x17F; bits 3:0 pick the input.
// - Slot codes 0..7 pick inputs 0..7; codes 8..15 are invalid.
// - Slots reset to zero, selecting input zero; bits 7:4 read zero.
// - Alert flags set only while threshold detection is enabled for that input; they clear one cycle after it is disabled.
`timescale 1ns/100ps
`default_nettype none

module channel_threshold_correction_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [regbank_pkg::PADDR_W-1:0] paddr,
    input wire logic [regbank_pkg::PDATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [regbank_pkg::PDATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic result_valid,
    input wire logic [regbank_pkg::INPUT_IDX_W-1:0] result_input,
    input wire logic [regbank_pkg::RESULT_W-1:0] result_data,
    input wire logic [regbank_pkg::SLOT_IDX_W-1:0] slot_index,
    output logic [regbank_pkg::SLOT_CODE_W-1:0] slot_input_select,
    output logic [regbank_pkg::NUM_INPUTS-1:0] analog_input_n,
    output logic slot_code_invalid,
    output logic [regbank_pkg::NUM_INPUTS-1:0][15:0] zero_trim,
    output logic [regbank_pkg::NUM_INPUTS-1:0][15:0] scale_trim,
    output logic [regbank_pkg::NUM_INPUTS-1:0] high_alert_flag,
    output logic [regbank_pkg::NUM_INPUTS-1:0] low_alert_flag,
    output logic irq
);
    import regbank_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_INPUTS-1:0][LIMIT_W-1:0] upper;
        logic [NUM_INPUTS-1:0][LIMIT_W-1:0] lower;
        logic [NUM_INPUTS-1:0][LIMIT_W-1:0] deadband;
        logic [NUM_INPUTS-1:0][TRIM_W-1:0] ztrim;
        logic [NUM_INPUTS-1:0][TRIM_W-1:0] strim;
        logic [NUM_SLOTS-1:0][SLOT_CODE_W-1:0] slot;
        logic [NUM_INPUTS-1:0] threshold_detect_enable;
        logic [NUM_INPUTS-1:0] hi;
        logic [NUM_INPUTS-1:0] lo;
        logic [15:0] status;
        logic [15:0] mask;
        logic irq;
        logic [PDATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic [SLOT_CODE_W-1:0] slot_code;
        logic [NUM_INPUTS-1:0] slot_onehot;
        logic slot_invalid;
        logic [6:0] chk_n;
        logic [15:0] chk_data;
        logic [NUM_INPUTS-1:0] chk_td;
    } state_t;

    localparam state_t RST_STATE = '{
        upper: {NUM_INPUTS{UPPER_RST}}, lower: {NUM_INPUTS{LOWER_RST}},
        deadband: {NUM_INPUTS{DEADBAND_RST}},
        ztrim: {NUM_INPUTS{ZERO_TRIM_RST}},
        strim: {NUM_INPUTS{SCALE_TRIM_RST}}, slot: {NUM_SLOTS{SLOT_RST}},
        threshold_detect_enable: TD_ENABLE_RST, hi: 8'h00, lo: 8'h00, status: 16'h0000,
        mask: IRQ_MASK_RST, irq: 1'b0, prdata: 32'h0000_0000,
        pready: 1'b0, pslverr: 1'b0, slot_code: SLOT_RST,
        slot_onehot: 8'h01, slot_invalid: 1'b0, chk_n: 7'h00,
        chk_data: 16'h0000, chk_td: TD_ENABLE_RST
    };

    state_t s_q;
    state_t s_d;
    decode_t dec;
    logic wr_fire;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic in_family(input logic [8:0] idx,
                                       input logic [8:0] base);
        in_family = (idx >= base) && (idx <= base + FAMILY_SPAN) && !idx[0];
    endfunction
    function automatic logic [6:0] family_n(input logic [8:0] idx,
                                            input logic [8:0] base);
        logic [8:0] off;
        off = idx - base;
        family_n = {4'h0, off[3:1]};
    endfunction
    function automatic decode_t decode_addr(input logic [PADDR_W-1:0] a);
        decode_t r;
        logic [8:0] idx;
        logic [8:0] off;
        r.kind = REG_NONE;
        r.n = 7'h00;
        idx = a[10:2];
        off = idx - SLOT_BASE;
        if (!a[11] && a[1:0] == 2'b00) begin
            if (idx >= SLOT_BASE && idx <= SLOT_LAST) begin
                r.kind = REG_SLOT;
                r.n = off[6:0];
            end else if (in_family(idx, UPPER_BASE)) begin
                r.kind = REG_UPPER;
                r.n = family_n(idx, UPPER_BASE);
            end else if (in_family(idx, LOWER_BASE)) begin
                r.kind = REG_LOWER;
                r.n = family_n(idx, LOWER_BASE);
            end else if (in_family(idx, DEADBAND_BASE)) begin
                r.kind = REG_DEADBAND;
                r.n = family_n(idx, DEADBAND_BASE);
            end else if (in_family(idx, ZERO_TRIM_BASE)) begin
                r.kind = REG_ZERO_TRIM;
                r.n = family_n(idx, ZERO_TRIM_BASE);
            end else if (in_family(idx, SCALE_TRIM_BASE)) begin
                r.kind = REG_SCALE_TRIM;
                r.n = family_n(idx, SCALE_TRIM_BASE);
            end else if (idx == TD_ENABLE_IDX) begin
                r.kind = REG_TD_ENABLE;
            end else if (idx == IRQ_STATUS_IDX) begin
                r.kind = REG_IRQ_STATUS;
            end else if (idx == IRQ_MASK_IDX) begin
                r.kind = REG_IRQ_MASK;
            end else if (idx == ALERT_STATE_IDX) begin
                r.kind = REG_ALERT;
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [PDATA_W-1:0] wd,
                                            input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // Reserved bits above each field read as zero
    function automatic logic [PDATA_W-1:0] read_word(input state_t s,
                                                     input decode_t d);
        logic [PDATA_W-1:0] r;
        r = 32'h0000_0000;
        case (d.kind)
            REG_UPPER: r[LIMIT_W-1:0] = s.upper[d.n[2:0]];
            REG_LOWER: r[LIMIT_W-1:0] = s.lower[d.n[2:0]];
            REG_DEADBAND: r[LIMIT_W-1:0] = s.deadband[d.n[2:0]];
            REG_ZERO_TRIM: r[TRIM_W-1:0] = s.ztrim[d.n[2:0]];
            REG_SCALE_TRIM: r[TRIM_W-1:0] = s.strim[d.n[2:0]];
            REG_SLOT: r[SLOT_CODE_W-1:0] = s.slot[d.n];
            REG_TD_ENABLE: r[NUM_INPUTS-1:0] = s.threshold_detect_enable;
            REG_IRQ_STATUS: r[15:0] = s.status;
            REG_IRQ_MASK: r[15:0] = s.mask;
            REG_ALERT: r[15:0] = {s.lo, s.hi};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    assign dec = decode_addr(paddr);
    assign wr_fire = psel && penable && pwrite && s_q.pready && !s_q.pslverr;

    always_comb begin
        logic [15:0] w16;
        logic [LIMIT_W-1:0] res;
        w16 = 16'h0000;
        res = result_data[RESULT_W-1:RESULT_TOP_LSB];
        s_d = s_q;
        // One wait-free access phase after every setup cycle
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (psel && !penable) begin
            s_d.pready = 1'b1;
            s_d.pslverr = (dec.kind == REG_NONE);
            s_d.prdata = read_word(s_q, dec);
        end
        if (wr_fire) begin
            case (dec.kind)
                REG_UPPER: begin
                    w16 = merge16(16'(s_q.upper[dec.n[2:0]]), pwdata, pstrb);
                    s_d.upper[dec.n[2:0]] = w16[LIMIT_W-1:0];
                end
                REG_LOWER: begin
                    w16 = merge16(16'(s_q.lower[dec.n[2:0]]), pwdata, pstrb);
                    s_d.lower[dec.n[2:0]] = w16[LIMIT_W-1:0];
                end
                REG_DEADBAND: begin
                    w16 = merge16({4'h0, s_q.deadband[dec.n[2:0]]}, pwdata,
                                  pstrb);
                    s_d.deadband[dec.n[2:0]] = w16[LIMIT_W-1:0];
                end
                REG_ZERO_TRIM: begin
                    s_d.ztrim[dec.n[2:0]] = merge16(s_q.ztrim[dec.n[2:0]],
                                                    pwdata, pstrb);
                end
                REG_SCALE_TRIM: begin
                    s_d.strim[dec.n[2:0]] = merge16(s_q.strim[dec.n[2:0]],
                                                    pwdata, pstrb);
                end
                REG_SLOT: begin
                    if (pstrb[0]) begin
                        s_d.slot[dec.n] = pwdata[SLOT_CODE_W-1:0];
                    end
                end
                REG_TD_ENABLE: begin
                    if (pstrb[0]) begin
                        s_d.threshold_detect_enable = pwdata[NUM_INPUTS-1:0];
                    end
                end
                REG_IRQ_STATUS: begin
                    w16 = merge16(16'h0000, pwdata, pstrb);
                    s_d.status = s_q.status & ~w16;
                end
                REG_IRQ_MASK: begin
                    s_d.mask = merge16(s_q.mask, pwdata, pstrb);
                end
                default: ;
            endcase
        end
        // Alarm tracking with deadband on the 12 top result bits
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (!s_q.threshold_detect_enable[i]) begin
                s_d.hi[i] = 1'b0;
                s_d.lo[i] = 1'b0;
            end else if (result_valid &&
                         result_input == INPUT_IDX_W'(i)) begin
                if (res > s_q.upper[i]) begin
                    s_d.hi[i] = 1'b1;
                end else if (({1'b0, res} + {1'b0, s_q.deadband[i]}) <
                             {1'b0, s_q.upper[i]}) begin
                    s_d.hi[i] = 1'b0;
                end
                if (res < s_q.lower[i]) begin
                    s_d.lo[i] = 1'b1;
                end else if ({1'b0, res} >
                             ({1'b0, s_q.lower[i]} +
                              {1'b0, s_q.deadband[i]})) begin
                    s_d.lo[i] = 1'b0;
                end
            end
        end
        // New alerts set status after the clear, so a set wins
        s_d.status[HI_FIELD_LSB +: NUM_INPUTS] =
            s_d.status[HI_FIELD_LSB +: NUM_INPUTS] | (s_d.hi & ~s_q.hi);
        s_d.status[LO_FIELD_LSB +: NUM_INPUTS] =
            s_d.status[LO_FIELD_LSB +: NUM_INPUTS] | (s_d.lo & ~s_q.lo);
        s_d.irq = |(s_d.status & s_d.mask);
        // Slot lookup for the sequencer
        s_d.slot_code = s_d.slot[slot_index];
        s_d.slot_invalid = s_d.slot_code[SLOT_INVALID_BIT];
        s_d.slot_onehot = s_d.slot_invalid ? 8'h00 :
                          (8'h01 << s_d.slot_code[2:0]);
        s_d.chk_n = dec.n;
        s_d.chk_data = pwdata[15:0];
        s_d.chk_td = s_q.threshold_detect_enable;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign slot_input_select = s_q.slot_code;
    assign analog_input_n = s_q.slot_onehot;
    assign slot_code_invalid = s_q.slot_invalid;
    assign zero_trim = s_q.ztrim;
    assign scale_trim = s_q.strim;
    assign high_alert_flag = s_q.hi;
    assign low_alert_flag = s_q.lo;
    assign irq = s_q.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_full_write;
        wr_fire && pstrb[1:0] == 2'b11;
    endsequence

    a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
        else $error("setup not answered in exactly one access cycle");
    a_upper_write: assert property (
        s_full_write and dec.kind == REG_UPPER |=>
        s_q.upper[s_q.chk_n[2:0]] == s_q.chk_data[LIMIT_W-1:0])
        else $error("upper limit write not stored");
    a_upper_reserved: assert property (
        s_setup and dec.kind == REG_UPPER |=> prdata[31:LIMIT_W] == 20'h0_0000)
        else $error("upper limit reserved bits not zero");
    a_lower_write: assert property (
        s_full_write and dec.kind == REG_LOWER |=>
        s_q.lower[s_q.chk_n[2:0]] == s_q.chk_data[LIMIT_W-1:0])
        else $error("lower limit write not stored");
    a_deadband_write: assert property (
        s_full_write and dec.kind == REG_DEADBAND |=>
        s_q.deadband[s_q.chk_n[2:0]] == s_q.chk_data[LIMIT_W-1:0])
        else $error("deadband write not stored");
    a_zero_trim_write: assert property (
        s_full_write and dec.kind == REG_ZERO_TRIM |=>
        zero_trim[s_q.chk_n[2:0]] == s_q.chk_data)
        else $error("zero trim write not on output");
    a_scale_trim_write: assert property (
        s_full_write and dec.kind == REG_SCALE_TRIM |=>
        scale_trim[s_q.chk_n[2:0]] == s_q.chk_data)
        else $error("scale trim write not on output");
    a_slot_write: assert property (
        wr_fire && pstrb[0] && dec.kind == REG_SLOT |=>
        s_q.slot[s_q.chk_n] == s_q.chk_data[SLOT_CODE_W-1:0])
        else $error("slot write not stored");
    a_slot_decode: assert property (
        slot_code_invalid == slot_input_select[SLOT_INVALID_BIT] &&
        (slot_code_invalid ? analog_input_n == 8'h00 :
         analog_input_n == (8'h01 << slot_input_select[2:0])))
        else $error("slot code decode wrong");
    a_slot_reserved: assert property (
        s_setup and dec.kind == REG_SLOT |=> prdata[31:SLOT_CODE_W] == 28'h0)
        else $error("slot reserved bits not zero");
    a_alert_gated: assert property (
        ((high_alert_flag | low_alert_flag) & ~s_q.chk_td) == 8'h00)
        else $error("alert flag while detection disabled");
    a_family_map: assert property (
        s_setup and dec.kind == REG_SCALE_TRIM |=>
        prdata[TRIM_W-1:0] == scale_trim[s_q.chk_n[2:0]])
        else $error("scale trim read maps to wrong input");
    a_irq_level: assert property (irq == |(s_q.status & s_q.mask))
        else $error("interrupt level disagrees with status and mask");

endmodule

`default_nettype wire

// ### testbench/channel_threshold_correction_regs_tb_top.sv
// Self-checking bench of the per-input threshold and trim registers
`timescale 1ns/100ps
`default_nettype none

module channel_threshold_correction_regs_tb_top;
    import regbank_pkg::*;

    logic clk, nrst, psel, penable, pwrite, result_valid, err;
    logic pready, pslverr, slot_code_invalid, irq;
    logic [PADDR_W-1:0] paddr;
    logic [PDATA_W-1:0] pwdata, prdata;
    logic [31:0] rd;
    logic [3:0] pstrb;
    logic [INPUT_IDX_W-1:0] result_input;
    logic [RESULT_W-1:0] result_data;
    logic [SLOT_IDX_W-1:0] slot_index;
    logic [SLOT_CODE_W-1:0] slot_input_select;
    logic [NUM_INPUTS-1:0] analog_input_n, high_alert_flag, low_alert_flag;
    logic [NUM_INPUTS-1:0][15:0] zero_trim, scale_trim;
    int bad_count, comparisons;

    channel_threshold_correction_regs channel_threshold_correction_regs_inst (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .result_valid(result_valid), .result_input(result_input),
        .result_data(result_data), .slot_index(slot_index),
        .slot_input_select(slot_input_select),
        .analog_input_n(analog_input_n),
        .slot_code_invalid(slot_code_invalid), .zero_trim(zero_trim),
        .scale_trim(scale_trim), .high_alert_flag(high_alert_flag),
        .low_alert_flag(low_alert_flag), .irq(irq)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [11:0] adr(input logic [8:0] idx);
        return {1'b0, idx, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits for pready under a bounded count
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic feed(input logic [2:0] ch, input logic [15:0] d);
        @(posedge clk);
        result_valid <= 1'b1;
        result_input <= ch;
        result_data <= d;
        @(posedge clk);
        result_valid <= 1'b0;
        @(negedge clk);
    endtask

    task automatic stop_test;
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        for (int n = 0; n < 8; n++) begin
            apb(1'b0, adr(UPPER_BASE + 9'(2 * n)), 32'h0000_0000);
            chk(rd, 32'h0000_07FF);
            apb(1'b0, adr(LOWER_BASE + 9'(2 * n)), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            apb(1'b0, adr(DEADBAND_BASE + 9'(2 * n)), 32'h0000_0000);
            chk(rd, 32'h0000_0010);
            apb(1'b0, adr(ZERO_TRIM_BASE + 9'(2 * n)), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            apb(1'b0, adr(SCALE_TRIM_BASE + 9'(2 * n)), 32'h0000_0000);
            chk(rd, 32'h0000_8000);
            chk({16'h0000, scale_trim[n]}, 32'h0000_8000);
        end
        apb(1'b0, adr(SLOT_LAST), 32'h0000_0000);
        chk(rd, 32'h0000_0000);
    endtask

    // Distinct values per input also expose address aliasing
    task automatic t_rw;
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, adr(UPPER_BASE + 9'(2 * n)), 32'hFFFF_FFF0 | n);
            apb(1'b1, adr(LOWER_BASE + 9'(2 * n)), 32'hF000_F120 | n);
            apb(1'b1, adr(DEADBAND_BASE + 9'(2 * n)), 32'h0000_F030 | n);
            apb(1'b1, adr(ZERO_TRIM_BASE + 9'(2 * n)), 32'hFFFF_5A00 | n);
            apb(1'b1, adr(SCALE_TRIM_BASE + 9'(2 * n)), 32'h0000_C300 | n);
        end
        for (int n = 0; n < 8; n++) begin
            apb(1'b0, adr(UPPER_BASE + 9'(2 * n)), 32'h0000_0000);
            chk(rd, 32'h0000_0FF0 | n);
            apb(1'b0, adr(LOWER_BASE + 9'(2 * n)), 32'h0000_0000);
            chk(rd, 32'h0000_0120 | n);
            apb(1'b0, adr(DEADBAND_BASE + 9'(2 * n)), 32'h0000_0000);
            chk(rd, 32'h0000_0030 | n);
            apb(1'b0, adr(ZERO_TRIM_BASE + 9'(2 * n)), 32'h0000_0000);
            chk(rd, 32'h0000_5A00 | n);
            chk({16'h0000, zero_trim[n]}, 32'h0000_5A00 | n);
            apb(1'b0, adr(SCALE_TRIM_BASE + 9'(2 * n)), 32'h0000_0000);
            chk(rd, 32'h0000_C300 | n);
            chk({16'h0000, scale_trim[n]}, 32'h0000_C300 | n);
        end
    endtask

    task automatic t_slot;
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, adr(SLOT_BASE + 9'(c)), 32'h0000_00F0 | c);
        end
        apb(1'b1, adr(SLOT_LAST), 32'h0000_0005);
        for (int c = 0; c < 16; c++) begin
            apb(1'b0, adr(SLOT_BASE + 9'(c)), 32'h0000_0000);
            chk(rd, 32'(c));
            slot_index <= 7'(c);
            @(posedge clk);
            @(negedge clk);
            chk({28'h0, slot_input_select}, 32'(c));
            chk({24'h0, analog_input_n}, c < 8 ? 32'(1 << c) : 32'h0);
            chk({31'h0, slot_code_invalid}, 32'(c >= 8));
        end
        @(posedge clk);
        slot_index <= 7'h7F;
        @(posedge clk);
        @(negedge clk);
        chk({28'h0, slot_input_select}, 32'h0000_0005);
    endtask

    task automatic t_unmapped;
        apb(1'b0, 12'h804, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b1, adr(9'h041), 32'h0000_0123);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b1, 12'h102, 32'h0000_0456);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, adr(UPPER_BASE), 32'h0000_0000);
        chk({err, rd[30:0]}, 32'h0000_0FF0);
    endtask

    task automatic t_alert;
        apb(1'b1, adr(UPPER_BASE + 9'h004), 32'h0000_0100);
        apb(1'b1, adr(IRQ_MASK_IDX), 32'h0000_000C);
        apb(1'b1, adr(TD_ENABLE_IDX), 32'h0000_0004);
        apb(1'b0, adr(TD_ENABLE_IDX), 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        feed(3'd3, 16'hFFF0);
        chk({23'h0, irq, high_alert_flag}, 32'h0000_0000);
        feed(3'd2, 16'h2000);
        chk({23'h0, irq, high_alert_flag}, 32'h0000_0104);
        apb(1'b0, adr(IRQ_STATUS_IDX), 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        apb(1'b1, adr(IRQ_STATUS_IDX), 32'h0000_0004);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({23'h0, irq, high_alert_flag}, 32'h0000_0004);
        // Below the lower limit: high clears by deadband, low rises
        feed(3'd2, 16'h0000);
        chk({16'h0, low_alert_flag, high_alert_flag}, 32'h0000_0400);
        apb(1'b0, adr(ALERT_STATE_IDX), 32'h0000_0000);
        chk(rd, 32'h0000_0400);
        apb(1'b0, adr(IRQ_STATUS_IDX), 32'h0000_0000);
        chk(rd, 32'h0000_0400);
        apb(1'b1, adr(TD_ENABLE_IDX), 32'h0000_0000);
        feed(3'd2, 16'h2000);
        @(negedge clk);
        chk({16'h0, low_alert_flag, high_alert_flag}, 32'h0000_0000);
    endtask

    // ------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #(25 * 40000);
        bad_count++;
        stop_test;
    end

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        result_valid = 1'b0;
        result_input = 3'h0;
        result_data = 16'h0000;
        slot_index = 7'h00;
        bad_count = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_rw;
        t_slot;
        t_unmapped;
        t_alert;
        stop_test;
    end
endmodule

`default_nettype wire
